/* File: design/sos_pkg.sv */
// constants shared by the output and scan block
package sos_pkg;
	// ------------------------------------------------------------
	// register map
	// ------------------------------------------------------------
	localparam logic [7:0] ADDR_CTRL     = 8'h00;
	localparam logic [7:0] ADDR_HS_DELAY = 8'h04;
	localparam logic [7:0] ADDR_HS_WIDTH = 8'h08;
	localparam logic [7:0] ADDR_STATUS   = 8'h0C;
	localparam logic [7:0] ADDR_INT_STAT = 8'h10;
	localparam logic [7:0] ADDR_INT_MASK = 8'h14;
	// ------------------------------------------------------------
	// control fields
	// ------------------------------------------------------------
	localparam int CTRL_SEL_DIGITAL = 0;
	localparam int CTRL_HS_OUT_POL  = 1;
	localparam int CTRL_VS_OUT_POL  = 2;
	localparam int CTRL_VS_COMPOSITE = 3;
	localparam int CTRL_POWER_DOWN  = 4;
	localparam int CTRL_SCAN_MODE   = 5;
	localparam int CTRL_HS_IN_POL   = 6;
	localparam int CTRL_W           = 7;
	localparam logic [CTRL_W-1:0] CTRL_RESET = 7'h00;
	localparam int TW = 12;
	localparam logic [TW-1:0] HS_DELAY_RESET = 12'h004;
	localparam logic [TW-1:0] HS_WIDTH_RESET = 12'h010;
	// ------------------------------------------------------------
	// interrupt bits
	// ------------------------------------------------------------
	localparam int IRQ_ACT_RISE = 0;
	localparam int IRQ_ACT_FALL = 1;
	localparam int IRQ_SCAN_FULL = 2;
	localparam int IRQ_W        = 3;
	// ------------------------------------------------------------
	// widths and timing
	// ------------------------------------------------------------
	localparam int SCAN_W = 48;
	localparam int SCAN_CW = 6;
	localparam logic [SCAN_CW-1:0] SCAN_LAST = 6'h2F;
	localparam int CLK_NS = 100;
	localparam int DETECT_TIMEOUT_NS = 200000;
	localparam int DETECT_CYC = DETECT_TIMEOUT_NS / CLK_NS;
	localparam int VSEP_MIN_NS = 8000;
	localparam int VSEP_CYC = (VSEP_MIN_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [TW-1:0] DETECT_LIMIT = TW'(DETECT_CYC);
	localparam logic [TW-1:0] VSEP_LIMIT = TW'(VSEP_CYC);
	// ------------------------------------------------------------
	// analog line sync generator
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		LS_IDLE  = 2'b00,
		LS_DELAY = 2'b01,
		LS_PULSE = 2'b10
	} sos_ls_e;
endpackage

/* File: design/sos_sync.sv */
// two-stage synchroniser with rising and falling edge pulses
module sos_sync #(
	parameter int W = 1
) (
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	input  wire logic [W-1:0] async_i,
	output logic      [W-1:0] level_o,
	output logic      [W-1:0] rise_o,
	output logic      [W-1:0] fall_o
);
	logic [W-1:0] meta;
	logic [W-1:0] prev;

	// ------------------------------------------------------------
	// per-bit synchroniser
	// ------------------------------------------------------------
	for (genvar i = 0; i < W; i++) begin : g_bit
		always_ff @(posedge clk_i) begin
			if (rst_i) begin
				meta[i]    <= 1'b0;
				level_o[i] <= 1'b0;
				prev[i]    <= 1'b0;
			end else begin
				meta[i]    <= async_i[i];
				level_o[i] <= meta[i];
				prev[i]    <= level_o[i];
			end
		end
		assign rise_o[i] = level_o[i] & ~prev[i];
		assign fall_o[i] = ~level_o[i] & prev[i];
	end
endmodule

/* File: design/sos_top.sv */
// shared sync, pixel data, activity detect and scan register outputs
// Behaviour
// - line sync out is derived from the active interface hsync, polarity from control bit
// - digital mode copies transmitter hsync timing; analog mode uses programmed delay, width
// - frame sync is composite-separated or direct vsync, polarity from control bit
// - frame sync follows transmitter timing, except composite mode, which rises only after csync stays high VSEP_LIMIT cycles
// - three colours, ports A even and B odd, 8 bits, bit 7 msb
// - data clock and complement come from the active interface
// - activity is analog hsync detection OR digital data-enable detection
// - activity goes low when both idle or the chip is powered down
// - pixel outputs float whenever activity is low
// - tester shifts one scan bit per scan clock into the 48-bit register
// - scan register contents appear in parallel on the 48 pixel outputs
// - scan output gives register contents first in first out, one per clock
// - one scan clock moves both scan input and scan output together
module sos_top (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// ahb-lite slave
	input  wire logic        hsel_i,
	input  wire logic [31:0] haddr_i,
	input  wire logic [1:0]  htrans_i,
	input  wire logic        hwrite_i,
	input  wire logic [2:0]  hsize_i,
	input  wire logic [31:0] hwdata_i,
	input  wire logic        hready_i,
	output logic      [31:0] hrdata_o,
	output logic             hreadyout_o,
	output logic             hresp_o,
	output logic             irq_o,
	// analog front end, same clock
	input  wire logic [23:0] ana_data_a_i,
	input  wire logic [23:0] ana_data_b_i,
	input  wire logic        ana_clk_i,
	// digital receiver, same clock
	input  wire logic [23:0] dig_data_a_i,
	input  wire logic [23:0] dig_data_b_i,
	input  wire logic        dig_clk_i,
	input  wire logic        dig_hsync_i,
	input  wire logic        dig_vsync_i,
	input  wire logic        dig_de_i,
	// sync pins
	input  wire logic        hsync_i,
	input  wire logic        vsync_i,
	input  wire logic        csync_i,
	// scan pins
	input  wire logic        scan_clk_i,
	input  wire logic        scan_in_i,
	output logic             scan_out_o,
	// shared outputs
	output logic             line_sync_out_o,
	output logic             frame_sync_out_o,
	output logic [7:0]       red_a_o,
	output logic [7:0]       green_a_o,
	output logic [7:0]       blue_a_o,
	output logic [7:0]       red_b_o,
	output logic [7:0]       green_b_o,
	output logic [7:0]       blue_b_o,
	output logic             data_oe_o,
	output logic             pixel_data_clock_out_o,
	output logic             pixel_data_clock_out_n_o,
	output logic             activity_detect_o
);
	// ------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------
	logic [sos_pkg::CTRL_W-1:0]  ctrl;
	logic [sos_pkg::TW-1:0]      hs_delay;
	logic [sos_pkg::TW-1:0]      hs_width;
	logic [sos_pkg::IRQ_W-1:0]   int_stat;
	logic [sos_pkg::IRQ_W-1:0]   int_mask;
	logic [sos_pkg::IRQ_W-1:0]   events;
	logic                        wr_pend;
	logic [7:0]                  wr_addr;
	logic                        addr_ok;
	logic [31:0]                 next_rdata;
	logic [4:0]                  pin_lvl;
	logic [4:0]                  pin_rise;
	logic [4:0]                  pin_fall;
	logic                        hs_lead;
	logic [sos_pkg::TW-1:0]      hs_age;
	logic [sos_pkg::TW-1:0]      de_age;
	logic                        hs_det;
	logic                        de_det;
	logic                        act;
	logic                        act_prev;
	sos_pkg::sos_ls_e            ls_state;
	logic [sos_pkg::TW-1:0]      ls_cnt;
	logic                        ana_line;
	logic [sos_pkg::TW-1:0]      cs_len;
	logic                        cs_vsync;
	logic [sos_pkg::SCAN_W-1:0]  scan_reg;
	logic [sos_pkg::SCAN_CW-1:0] scan_cnt;
	logic                        scan_full;
	logic [47:0]                 pix;
	logic                        sel_dig;

	assign sel_dig = ctrl[sos_pkg::CTRL_SEL_DIGITAL];

	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	sos_sync #(
		.W(5)
	) u_sync (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.async_i({scan_in_i, scan_clk_i, csync_i, vsync_i, hsync_i}),
		.level_o(pin_lvl),
		.rise_o (pin_rise),
		.fall_o (pin_fall)
	);

	assign hs_lead = ctrl[sos_pkg::CTRL_HS_IN_POL] ? pin_rise[0] : pin_fall[0];

	// ------------------------------------------------------------
	// ahb-lite slave
	// ------------------------------------------------------------
	always_comb begin
		addr_ok = 1'b1;
		next_rdata = 32'h0000_0000;
		case (haddr_i[7:0])
			sos_pkg::ADDR_CTRL:     next_rdata[sos_pkg::CTRL_W-1:0] = ctrl;
			sos_pkg::ADDR_HS_DELAY: next_rdata[sos_pkg::TW-1:0] = hs_delay;
			sos_pkg::ADDR_HS_WIDTH: next_rdata[sos_pkg::TW-1:0] = hs_width;
			sos_pkg::ADDR_STATUS:   next_rdata[1:0] = {sel_dig, act};
			sos_pkg::ADDR_INT_STAT: next_rdata[sos_pkg::IRQ_W-1:0] = int_stat;
			sos_pkg::ADDR_INT_MASK: next_rdata[sos_pkg::IRQ_W-1:0] = int_mask;
			default:                addr_ok = 1'b0;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wr_pend     <= 1'b0;
			wr_addr     <= 8'h00;
			hrdata_o    <= 32'h0000_0000;
			hreadyout_o <= 1'b1;
			hresp_o     <= 1'b0;
		end else begin
			wr_pend <= hsel_i & htrans_i[1] & hready_i & hwrite_i & addr_ok;
			if (hsel_i & htrans_i[1] & hready_i) begin
				wr_addr  <= haddr_i[7:0];
				hrdata_o <= hwrite_i ? 32'h0000_0000 : next_rdata;
			end
		end
	end

	// configuration registers written in the data phase
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl     <= sos_pkg::CTRL_RESET;
			hs_delay <= sos_pkg::HS_DELAY_RESET;
			hs_width <= sos_pkg::HS_WIDTH_RESET;
			int_mask <= '0;
		end else if (wr_pend) begin
			case (wr_addr)
				sos_pkg::ADDR_CTRL:     ctrl <= hwdata_i[sos_pkg::CTRL_W-1:0];
				sos_pkg::ADDR_HS_DELAY: hs_delay <= hwdata_i[sos_pkg::TW-1:0];
				sos_pkg::ADDR_HS_WIDTH: hs_width <= hwdata_i[sos_pkg::TW-1:0];
				sos_pkg::ADDR_INT_MASK: int_mask <= hwdata_i[sos_pkg::IRQ_W-1:0];
				default:                ;
			endcase
		end
	end

	// ------------------------------------------------------------
	// interrupts: sticky, write one to clear, set wins
	// ------------------------------------------------------------
	assign events = {scan_full, act_prev & ~act, act & ~act_prev};

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			int_stat <= '0;
			irq_o    <= 1'b0;
		end else begin
			if (wr_pend && wr_addr == sos_pkg::ADDR_INT_STAT) begin
				int_stat <= (int_stat & ~hwdata_i[sos_pkg::IRQ_W-1:0]) | events;
			end else begin
				int_stat <= int_stat | events;
			end
			irq_o <= |(int_stat & int_mask);
		end
	end

	// ------------------------------------------------------------
	// activity detection
	// ------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			hs_age <= sos_pkg::DETECT_LIMIT;
			de_age <= sos_pkg::DETECT_LIMIT;
		end else begin
			if (hs_lead) begin
				hs_age <= '0;
			end else if (hs_age != sos_pkg::DETECT_LIMIT) begin
				hs_age <= hs_age + 1'b1;
			end
			if (dig_de_i) begin
				de_age <= '0;
			end else if (de_age != sos_pkg::DETECT_LIMIT) begin
				de_age <= de_age + 1'b1;
			end
		end
	end

	assign hs_det = hs_age != sos_pkg::DETECT_LIMIT;
	assign de_det = de_age != sos_pkg::DETECT_LIMIT;
	assign act = (hs_det | de_det) & ~ctrl[sos_pkg::CTRL_POWER_DOWN];

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			act_prev          <= 1'b0;
			activity_detect_o <= 1'b0;
		end else begin
			act_prev          <= act;
			activity_detect_o <= act;
		end
	end

	// ------------------------------------------------------------
	// analog line sync: programmed delay and width
	// ------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ls_state <= sos_pkg::LS_IDLE;
			ls_cnt   <= '0;
			ana_line <= 1'b0;
		end else begin
			case (ls_state)
				sos_pkg::LS_IDLE: begin
					ana_line <= 1'b0;
					if (hs_lead) begin
						ls_cnt   <= '0;
						ls_state <= sos_pkg::LS_DELAY;
					end
				end
				sos_pkg::LS_DELAY: begin
					if (ls_cnt >= hs_delay) begin
						ls_cnt   <= '0;
						ana_line <= 1'b1;
						ls_state <= sos_pkg::LS_PULSE;
					end else begin
						ls_cnt <= ls_cnt + 1'b1;
					end
				end
				sos_pkg::LS_PULSE: begin
					if (ls_cnt + 1'b1 >= hs_width) begin
						ana_line <= 1'b0;
						ls_state <= sos_pkg::LS_IDLE;
					end else begin
						ls_cnt <= ls_cnt + 1'b1;
					end
				end
				default: begin
					ana_line <= 1'b0;
					ls_state <= sos_pkg::LS_IDLE;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// composite sync vertical separation
	// ------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cs_len   <= '0;
			cs_vsync <= 1'b0;
		end else if (pin_lvl[2]) begin
			if (cs_len != sos_pkg::VSEP_LIMIT) begin
				cs_len <= cs_len + 1'b1;
			end else begin
				cs_vsync <= 1'b1;
			end
		end else begin
			cs_len   <= '0;
			cs_vsync <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// sync outputs
	// ------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			line_sync_out_o  <= 1'b0;
			frame_sync_out_o <= 1'b0;
		end else begin
			// digital passes transmitter timing, analog uses generator
			line_sync_out_o <= (sel_dig ? dig_hsync_i : ana_line)
				^ ctrl[sos_pkg::CTRL_HS_OUT_POL];
			// frame sync is passed through, except composite mode starts it after csync is high VSEP_LIMIT cycles
			frame_sync_out_o <= (sel_dig ? dig_vsync_i :
				(ctrl[sos_pkg::CTRL_VS_COMPOSITE] ? cs_vsync : pin_lvl[1]))
				^ ctrl[sos_pkg::CTRL_VS_OUT_POL];
		end
	end

	// ------------------------------------------------------------
	// scan register on scan clock rise
	// ------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			scan_reg   <= '0;
			scan_cnt   <= '0;
			scan_full  <= 1'b0;
			scan_out_o <= 1'b0;
		end else begin
			scan_full <= 1'b0;
			if (pin_rise[3]) begin
				scan_reg   <= {scan_reg[sos_pkg::SCAN_W-2:0], pin_lvl[4]};
				scan_out_o <= scan_reg[sos_pkg::SCAN_W-1];
				if (scan_cnt == sos_pkg::SCAN_LAST) begin
					scan_cnt  <= '0;
					scan_full <= 1'b1;
				end else begin
					scan_cnt <= scan_cnt + 1'b1;
				end
			end
		end
	end

	// ------------------------------------------------------------
	// pixel data and data clock
	// ------------------------------------------------------------
	always_comb begin
		if (ctrl[sos_pkg::CTRL_SCAN_MODE]) begin
			pix = scan_reg;
		end else if (sel_dig) begin
			pix = {dig_data_b_i, dig_data_a_i};
		end else begin
			pix = {ana_data_b_i, ana_data_a_i};
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			{blue_b_o, green_b_o, red_b_o} <= 24'h000000;
			{blue_a_o, green_a_o, red_a_o} <= 24'h000000;
			data_oe_o                <= 1'b0;
			pixel_data_clock_out_o   <= 1'b0;
			pixel_data_clock_out_n_o <= 1'b1;
		end else begin
			// each colour: a holds even pixels, b odd, bit 7 msb
			{blue_a_o, green_a_o, red_a_o} <= pix[23:0];
			{blue_b_o, green_b_o, red_b_o} <= pix[47:24];
			data_oe_o <= act;
			pixel_data_clock_out_o   <= sel_dig ? dig_clk_i : ana_clk_i;
			pixel_data_clock_out_n_o <= ~(sel_dig ? dig_clk_i : ana_clk_i);
		end
	end
endmodule

/* File: dv/sos_gfx_sink.sv */
// downstream graphics controller latching pixels on the data clock
module sos_gfx_sink (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        dck_i,
	input  wire logic        oe_i,
	input  wire logic        ls_i,
	input  wire logic        fs_i,
	input  wire logic [47:0] pix_i,
	output logic             cap_v_o,
	output logic      [49:0] cap_d_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic        dck_q;
	logic [47:0] flt;
	logic [47:0] bus;
	// a released bus wanders every cycle
	assign bus = oe_i ? pix_i : flt;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dck_q   <= 1'b0;
			flt     <= 48'h5A5AC3C30F0F;
			cap_v_o <= 1'b0;
			cap_d_o <= 50'h0;
		end else begin
			dck_q   <= dck_i;
			flt     <= ~flt;
			cap_v_o <= dck_i & ~dck_q;
			if (dck_i && !dck_q)
				cap_d_o <= {ls_i, fs_i, bus};
		end
	end
endmodule

/* File: dv/sos_properties.sv */
// port assertions for the shared output and scan block
module sos_properties (
	input wire logic        clk_i, rst_i, hsel_i, hwrite_i, hready_i,
	input wire logic [31:0] haddr_i, hwdata_i,
	input wire logic [1:0]  htrans_i,
	input wire logic [23:0] ana_data_a_i, ana_data_b_i, dig_data_a_i, dig_data_b_i,
	input wire logic        ana_clk_i, dig_clk_i, dig_hsync_i, vsync_i, scan_clk_i,
	input wire logic        scan_out_o, line_sync_out_o, frame_sync_out_o, data_oe_o,
	input wire logic [7:0]  red_a_o, green_a_o, blue_a_o, red_b_o, green_b_o, blue_b_o,
	input wire logic        pixel_data_clock_out_o, pixel_data_clock_out_n_o,
	input wire logic        activity_detect_o, hresp_o
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	logic [6:0]  ctl;
	logic [3:0]  age;
	logic [3:0]  sc_age;
	logic [7:0]  wa;
	logic        wr_p;
	logic        sc_q;
	logic        dig;
	logic        ana;
	logic [47:0] pix;
	assign pix = {blue_b_o, green_b_o, red_b_o, blue_a_o, green_a_o, red_a_o};
	assign dig = ctl[0] & ~ctl[4] & ~ctl[5] & (age > 4'h1);
	assign ana = ~ctl[0] & ~ctl[4] & ~ctl[5] & (age > 4'h1);
	// ------------------------------------------------------------
	// shadow of the control register and its age
	// ------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		wa <= haddr_i[7:0];
		if (rst_i) begin
			wr_p <= 1'b0;
			ctl  <= 7'h00;
			age  <= 4'h0;
		end else begin
			wr_p <= hsel_i & htrans_i[1] & hready_i & hwrite_i;
			if (wr_p && wa == sos_pkg::ADDR_CTRL) begin
				ctl <= hwdata_i[6:0];
				age <= 4'h0;
			end else if (age != 4'hF) begin
				age <= age + 4'h1;
			end
		end
	end
	// cycles since the scan clock pin rose
	always_ff @(posedge clk_i) begin
		sc_q <= scan_clk_i;
		if (rst_i)
			sc_age <= 4'hF;
		else if (scan_clk_i && !sc_q)
			sc_age <= 4'h0;
		else if (sc_age != 4'hF)
			sc_age <= sc_age + 4'h1;
	end
	a_digital_route: assert property (
		dig |-> pix == $past({dig_data_b_i, dig_data_a_i})) else $error("digital pixels wrong");
	a_analog_route: assert property (
		ana |-> pix == $past({ana_data_b_i, ana_data_a_i})) else $error("analog pixels wrong");
	a_clock_source: assert property (
		(dig || ana) |-> pixel_data_clock_out_o == $past(ctl[0] ? dig_clk_i : ana_clk_i))
		else $error("data clock source wrong");
	a_clock_pair: assert property (
		pixel_data_clock_out_n_o != pixel_data_clock_out_o) else $error("clock pair broken");
	a_line_copy: assert property (
		dig |-> line_sync_out_o == ($past(dig_hsync_i) ^ ctl[1])) else $error("line sync wrong");
	a_frame_direct: assert property (
		ana && age > 4'h3 && !ctl[3] |-> frame_sync_out_o == ($past(vsync_i, 3) ^ ctl[2]))
		else $error("frame sync wrong");
	a_power_down: assert property (
		ctl[4] && age > 4'h3 |-> !activity_detect_o) else $error("active in power down");
	a_active_drives: assert property (
		activity_detect_o && $past(activity_detect_o) |-> data_oe_o) else $error("not driven");
	a_scan_drives: assert property (
		ctl[5] && age > 4'h2 && activity_detect_o |-> data_oe_o) else $error("scan not driven");
	a_idle_floats: assert property (
		!activity_detect_o |-> !data_oe_o) else $error("pixels driven while idle");
	a_okay_response: assert property (
		hresp_o == 1'b0) else $error("bus response not okay");
	a_scan_out_step: assert property (
		$changed(scan_out_o) |-> sc_age < 4'h7) else $error("scan out moved alone");
	a_scan_parallel: assert property (
		ctl[5] && age > 4'h3 && $changed(pix) |-> sc_age < 4'h7) else $error("scan pixels moved");
endmodule
bind sos_top sos_properties u_sos_properties (.*);

/* File: dv/tb_sos_top.sv */
// self-checking bench for the shared output and scan block
module tb_sos_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        hsel_i, hwrite_i, ana_clk_i, dig_clk_i, dig_hsync_i, dig_vsync_i, dig_de_i;
	logic        hsync_i, vsync_i, csync_i, scan_clk_i, scan_in_i, res_v, cap_v, de_run;
	logic [31:0] haddr_i, hwdata_i, hrdata_o, r;
	logic [1:0]  htrans_i;
	logic [2:0]  hsize_i;
	logic [23:0] ana_data_a_i, ana_data_b_i, dig_data_a_i, dig_data_b_i;
	logic [7:0]  red_a_o, green_a_o, blue_a_o, red_b_o, green_b_o, blue_b_o;
	logic        hreadyout_o, hresp_o, irq_o, scan_out_o, line_sync_out_o, frame_sync_out_o;
	logic        data_oe_o, pixel_data_clock_out_o, pixel_data_clock_out_n_o, activity_detect_o;
	logic [49:0] res, cap_d;
	logic [49:0] exp_q[$];
	logic [47:0] pat, ow;
	int          seed = 28;
	int          n_errors = 0;
	int          n_compared = 0;
	int          n, w;
	int          dl[2];
	always #50 clk_i = ~clk_i;
	sos_top u_sos_top (.*, .hready_i(hreadyout_o));
	sos_gfx_sink u_sos_gfx_sink (.clk_i(clk_i), .rst_i(rst_i), .dck_i(pixel_data_clock_out_o),
		.oe_i(data_oe_o), .ls_i(line_sync_out_o), .fs_i(frame_sync_out_o),
		.pix_i({blue_b_o, green_b_o, red_b_o, blue_a_o, green_a_o, red_a_o}),
		.cap_v_o(cap_v), .cap_d_o(cap_d));
	// transmitter data enable toggles while running
	always @(posedge clk_i) dig_de_i <= de_run & ~dig_de_i;
	task automatic tally_and_finish();
		$display("errors %0d compared %0d", n_errors, n_compared);
		if (n_errors == 0 && n_compared > 0 && exp_q.size() == 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic stuck();
		n_errors++;
		tally_and_finish();
	endtask
	task automatic cmp(input logic [49:0] e, input logic [49:0] g);
		n_compared++;
		if (g !== e) begin
			n_errors++;
			$display("FAIL t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask
	// monitor: oldest note against each result that appears
	always @(posedge clk_i) begin
		if (res_v)
			cmp(exp_q.pop_front(), res);
		if (cap_v)
			cmp(exp_q.pop_front(), cap_d);
	end
	function automatic logic [47:0] rnd();
		return {16'($random(seed)), 32'($random(seed))};
	endfunction
	task automatic note(input logic [49:0] e, input logic [49:0] g);
		exp_q.push_back(e);
		res   <= g;
		res_v <= 1'b1;
		@(posedge clk_i);
		res_v <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic hwait();
		int k;
		k = 0;
		@(posedge clk_i);
		while (hreadyout_o !== 1'b1) begin
			k++;
			if (k > 50)
				stuck();
			@(posedge clk_i);
		end
	endtask
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		hsel_i   <= 1'b1;
		haddr_i  <= {24'h000000, a};
		hwrite_i <= wr;
		htrans_i <= 2'h2;
		hwait();
		htrans_i <= 2'h0;
		hsel_i   <= 1'b0;
		hwdata_i <= d;
		hwait();
		r = hrdata_o;
		@(posedge clk_i);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		note({18'h0, e}, {18'h0, r});
	endtask
	task automatic cap(input logic ana, input logic [49:0] e);
		exp_q.push_back(e);
		repeat (6) @(posedge clk_i);
		if (ana)
			ana_clk_i <= 1'b1;
		else
			dig_clk_i <= 1'b1;
		repeat (6) @(posedge clk_i);
		ana_clk_i <= 1'b0;
		dig_clk_i <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic shift(input logic [47:0] p);
		for (int i = 47; i >= 0; i--) begin
			scan_in_i  <= p[i];
			@(posedge clk_i);
			scan_clk_i <= 1'b1;
			repeat (4) @(posedge clk_i);
			scan_clk_i <= 1'b0;
			repeat (3) @(posedge clk_i);
			ow = {ow[46:0], scan_out_o};
		end
	endtask
	initial begin
		{hsel_i, hwrite_i, ana_clk_i, dig_clk_i, dig_hsync_i, dig_vsync_i} = '0;
		{hsync_i, vsync_i, csync_i, scan_clk_i, scan_in_i, res_v, de_run} = '0;
		{haddr_i, hwdata_i, htrans_i, ana_data_a_i, ana_data_b_i} = '0;
		{dig_data_a_i, dig_data_b_i, res, ow} = '0;
		hsize_i = 3'h2;
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(sos_pkg::ADDR_CTRL, 32'h0);
		rd(sos_pkg::ADDR_HS_DELAY, 32'h4);
		rd(sos_pkg::ADDR_HS_WIDTH, 32'h10);
		rd(8'h40, 32'h0);
		bus(1'b1, sos_pkg::ADDR_CTRL, 32'h1);
		{hsync_i, dig_hsync_i, vsync_i, dig_vsync_i, de_run} <= 5'h1F;
		n = 0;
		while (activity_detect_o !== 1'b1) begin
			n++;
			if (n > 2100)
				stuck();
			@(posedge clk_i);
		end
		rd(sos_pkg::ADDR_STATUS, 32'h3);
		for (int k = 0; k < 4; k++) begin
			bus(1'b1, sos_pkg::ADDR_CTRL, 32'(2 * k + 1));
			pat = rnd();
			{dig_data_b_i, dig_data_a_i} <= pat;
			{ana_data_b_i, ana_data_a_i} <= rnd();
			cap(1'b0, {~k[0], ~k[1], pat});
		end
		bus(1'b1, sos_pkg::ADDR_CTRL, 32'h0);
		pat = rnd();
		{ana_data_b_i, ana_data_a_i} <= pat;
		{dig_data_b_i, dig_data_a_i} <= ~pat;
		cap(1'b1, {2'h1, pat});
		for (int j = 0; j < 2; j++) begin
			bus(1'b1, sos_pkg::ADDR_HS_DELAY, 32'(2 + 7 * j));
			bus(1'b1, sos_pkg::ADDR_HS_WIDTH, 32'(3 + 4 * j));
			hsync_i <= 1'b0;
			n = 0;
			while (line_sync_out_o !== 1'b1 && n < 300) begin
				n++;
				@(posedge clk_i);
			end
			w = 0;
			while (line_sync_out_o === 1'b1 && w < 300) begin
				w++;
				@(posedge clk_i);
			end
			if (n >= 300 || w >= 300)
				stuck();
			dl[j] = n;
			note(50'(3 + 4 * j), 50'(w));
			hsync_i <= 1'b1;
			repeat (20) @(posedge clk_i);
		end
		note(50'h7, 50'(dl[1] - dl[0]));
		bus(1'b1, sos_pkg::ADDR_INT_STAT, 32'h7);
		bus(1'b1, sos_pkg::ADDR_INT_MASK, 32'h4);
		bus(1'b1, sos_pkg::ADDR_CTRL, 32'h20);
		pat = rnd();
		shift(pat);
		cap(1'b1, {2'h1, pat});
		rd(sos_pkg::ADDR_INT_STAT, 32'h4);
		note(50'h1, {49'h0, irq_o});
		shift(rnd());
		note({2'h0, pat}, {2'h0, ow});
		bus(1'b1, sos_pkg::ADDR_INT_STAT, 32'h4);
		rd(sos_pkg::ADDR_INT_STAT, 32'h0);
		note(50'h0, {49'h0, irq_o});
		bus(1'b1, sos_pkg::ADDR_CTRL, 32'h8);
		csync_i <= 1'b1;
		repeat (40) @(posedge clk_i);
		note(50'h0, {49'h0, frame_sync_out_o});
		repeat (48) @(posedge clk_i);
		note(50'h1, {49'h0, frame_sync_out_o});
		csync_i <= 1'b0;
		repeat (6) @(posedge clk_i);
		note(50'h0, {49'h0, frame_sync_out_o});
		bus(1'b1, sos_pkg::ADDR_CTRL, 32'h11);
		repeat (8) @(posedge clk_i);
		rd(sos_pkg::ADDR_STATUS, 32'h2);
		note(50'h0, {49'h0, data_oe_o});
		tally_and_finish();
	end
endmodule
